// ==== hdl/lfm_l4_matcher.sv ====
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`include "lfm_defines.svh"
// Overview of operation
// - Port mode any ignores destination port.
// - Single mode needs port equal value.
// - Range mode needs port within bounds inclusive.
// - URG flag set, unset or don't care.
// - ACK flag set, unset or don't care.
// - PSH flag set, unset or don't care.
// - RST flag set, unset or don't care.
// - SYN flag set, unset or don't care.
// - FIN flag set, unset or don't care.
// - Service mode any ignores service byte.
// - DSCP mode needs DSCP field equal value.
// - Priority mode needs precedence bits equal.
// - ICMP type any accepts every type.
// - Explicit ICMP type must equal frame type.
// - ICMP code any ignores code field.
// - Defined ICMP code must equal frame code.
// - Hit applies permit forward or deny drop.
// - Mask bit zero compares, one ignores.
module lfm_l4_matcher (
    // Clock, reset and clock enable.
    input  wire logic        i_ref_clk,
    input  wire logic        i_arst_n,
    input  wire logic        i_clk_en,
    // Register port.
    input  wire logic [7:0]  i_addr,
    input  wire logic [31:0] i_wr_data,
    input  wire logic        i_wr_en,
    input  wire logic        i_rd_en,
    output logic      [31:0] o_rd_data,
    // Parsed header fields from the ingress parser.
    input  wire logic        i_frm_valid,
    input  wire logic [31:0] i_frm_sip,
    input  wire logic [31:0] i_frm_dip,
    input  wire logic [15:0] i_frm_dport,
    input  wire logic [5:0]  i_frm_tcp_flags,
    input  wire logic [7:0]  i_frm_tos,
    input  wire logic [7:0]  i_frm_icmp_type,
    input  wire logic [7:0]  i_frm_icmp_code,
    // Classification result.
    output logic             o_res_valid,
    output logic             o_hit,
    output logic             o_forward,
    output logic             o_learn,
    output logic             o_drop,
    output logic             o_shutdown
);
    import lfm_pkg::*;

    logic           ctrl_en;
    lfm_port_mode_e dport_mode;
    lfm_tos_mode_e  tos_mode;
    logic           itype_en;
    logic           icode_en;
    lfm_action_e    action;
    logic [15:0]    dport_lo;
    logic [15:0]    dport_hi;
    logic [11:0]    flag_crit;
    logic [5:0]     dscp;
    logic [2:0]     prec;
    logic [7:0]     itype;
    logic [7:0]     icode;
    logic [31:0]    sip;
    logic [31:0]    sip_mask;
    logic [31:0]    dip;
    logic [31:0]    dip_mask;
    logic [31:0]    hit_cnt;

    lfm_cmp_if cmp ();

    assign cmp.dport_mode = dport_mode;
    assign cmp.tos_mode   = tos_mode;
    assign cmp.dport_lo   = dport_lo;
    assign cmp.dport_hi   = dport_hi;
    assign cmp.flag_crit  = flag_crit;
    assign cmp.dscp       = dscp;
    assign cmp.prec       = prec;
    assign cmp.itype_en   = itype_en;
    assign cmp.itype      = itype;
    assign cmp.icode_en   = icode_en;
    assign cmp.icode      = icode;
    assign cmp.sip        = sip;
    assign cmp.sip_mask   = sip_mask;
    assign cmp.dip        = dip;
    assign cmp.dip_mask   = dip_mask;
    assign cmp.frm_dport  = i_frm_dport;
    assign cmp.frm_flags  = i_frm_tcp_flags;
    assign cmp.frm_tos    = i_frm_tos;
    assign cmp.frm_itype  = i_frm_icmp_type;
    assign cmp.frm_icode  = i_frm_icmp_code;
    assign cmp.frm_sip    = i_frm_sip;
    assign cmp.frm_dip    = i_frm_dip;

    lfm_field_cmp u_cmp (
        .c (cmp.cmp)
    );

    // Every criterion of the entry must hold together.
    wire all_met = ctrl_en && cmp.dport_ok && (&cmp.flags_ok) &&
                   cmp.tos_ok && cmp.itype_ok && cmp.icode_ok &&
                   cmp.sip_ok && cmp.dip_ok;
    wire take    = i_clk_en && i_frm_valid;
    wire is_perm = (action == LFM_ACT_PERMIT);
    wire is_shut = (action == LFM_ACT_SHUTDOWN);

    wire wr_ctrl  = i_wr_en && (i_addr == `LFM_OFF_CTRL);
    wire wr_dlo   = i_wr_en && (i_addr == `LFM_OFF_DPORT_LO);
    wire wr_dhi   = i_wr_en && (i_addr == `LFM_OFF_DPORT_HI);
    wire wr_flags = i_wr_en && (i_addr == `LFM_OFF_FLAGS);
    wire wr_tos   = i_wr_en && (i_addr == `LFM_OFF_TOS);
    wire wr_icmp  = i_wr_en && (i_addr == `LFM_OFF_ICMP);
    wire wr_sip   = i_wr_en && (i_addr == `LFM_OFF_SIP);
    wire wr_smask = i_wr_en && (i_addr == `LFM_OFF_SIP_MASK);
    wire wr_dip   = i_wr_en && (i_addr == `LFM_OFF_DIP);
    wire wr_dmask = i_wr_en && (i_addr == `LFM_OFF_DIP_MASK);
    wire wr_cnt   = i_wr_en && (i_addr == `LFM_OFF_HIT_CNT);

    wire [31:0] rd_ctrl   = {23'h0, action, icode_en, itype_en, tos_mode,
                             dport_mode, ctrl_en};
    wire [31:0] rd_tos    = {21'h0, prec, 2'h0, dscp};
    wire [31:0] rd_icmp   = {16'h0, icode, itype};
    wire [31:0] rd_status = {29'h0, o_drop, o_forward, o_hit};
    wire [31:0] rd_mux =
        (i_addr == `LFM_OFF_CTRL)     ? rd_ctrl :
        (i_addr == `LFM_OFF_DPORT_LO) ? {16'h0, dport_lo} :
        (i_addr == `LFM_OFF_DPORT_HI) ? {16'h0, dport_hi} :
        (i_addr == `LFM_OFF_FLAGS)    ? {20'h0, flag_crit} :
        (i_addr == `LFM_OFF_TOS)      ? rd_tos :
        (i_addr == `LFM_OFF_ICMP)     ? rd_icmp :
        (i_addr == `LFM_OFF_SIP)      ? sip :
        (i_addr == `LFM_OFF_SIP_MASK) ? sip_mask :
        (i_addr == `LFM_OFF_DIP)      ? dip :
        (i_addr == `LFM_OFF_DIP_MASK) ? dip_mask :
        (i_addr == `LFM_OFF_STATUS)   ? rd_status :
        (i_addr == `LFM_OFF_HIT_CNT)  ? hit_cnt : 32'h0;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_en    <= 1'b0;
            dport_mode <= LFM_PORT_ANY;
            tos_mode   <= LFM_TOS_ANY;
            itype_en   <= 1'b0;
            icode_en   <= 1'b0;
            action     <= LFM_ACT_PERMIT;
        end else if (i_clk_en && wr_ctrl) begin
            ctrl_en    <= i_wr_data[`LFM_CTRL_EN_BIT];
            dport_mode <= lfm_port_mode_e'(
                          i_wr_data[`LFM_CTRL_DPMODE_LSB +: 2]);
            tos_mode   <= lfm_tos_mode_e'(
                          i_wr_data[`LFM_CTRL_TOSMODE_LSB +: 2]);
            itype_en   <= i_wr_data[`LFM_CTRL_ITYPE_BIT];
            icode_en   <= i_wr_data[`LFM_CTRL_ICODE_BIT];
            action     <= lfm_action_e'(i_wr_data[`LFM_CTRL_ACT_LSB +: 2]);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dport_lo  <= `LFM_RST_DPORT_LO;
            dport_hi  <= `LFM_RST_DPORT_HI;
            flag_crit <= `LFM_RST_FLAGS;
        end else if (i_clk_en) begin
            if (wr_dlo) begin
                dport_lo <= i_wr_data[15:0];
            end
            if (wr_dhi) begin
                dport_hi <= i_wr_data[15:0];
            end
            if (wr_flags) begin
                flag_crit <= i_wr_data[11:0];
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dscp  <= 6'h0;
            prec  <= 3'h0;
            itype <= 8'h0;
            icode <= 8'h0;
        end else if (i_clk_en) begin
            if (wr_tos) begin
                dscp <= i_wr_data[`LFM_TOS_DSCP_LSB +: 6];
                prec <= i_wr_data[`LFM_TOS_PREC_LSB +: 3];
            end
            if (wr_icmp) begin
                itype <= i_wr_data[`LFM_ICMP_TYPE_LSB +: 8];
                icode <= i_wr_data[`LFM_ICMP_CODE_LSB +: 8];
            end
        end
    end

    // Masks reset to all ones so that the address criteria start open.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sip      <= `LFM_RST_ADDR;
            sip_mask <= `LFM_RST_MASK;
            dip      <= `LFM_RST_ADDR;
            dip_mask <= `LFM_RST_MASK;
        end else if (i_clk_en) begin
            if (wr_sip) begin
                sip <= i_wr_data;
            end
            if (wr_smask) begin
                sip_mask <= i_wr_data;
            end
            if (wr_dip) begin
                dip <= i_wr_data;
            end
            if (wr_dmask) begin
                dip_mask <= i_wr_data;
            end
        end
    end

    // A hit in the cycle of a counter write is counted after the clear, loading one.
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            hit_cnt <= 32'h0;
        end else if (i_clk_en) begin
            if (take && all_met) begin
                hit_cnt <= wr_cnt ? 32'h1 : hit_cnt + 32'h1;
            end else if (wr_cnt) begin
                hit_cnt <= 32'h0;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rd_data <= 32'h0;
        end else if (i_clk_en) begin
            o_rd_data <= i_rd_en ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_res_valid <= 1'b0;
            o_hit       <= 1'b0;
            o_forward   <= 1'b0;
            o_learn     <= 1'b0;
            o_drop      <= 1'b0;
            o_shutdown  <= 1'b0;
        end else if (i_clk_en) begin
            o_res_valid <= i_frm_valid;
            if (i_frm_valid) begin
                o_hit      <= all_met;
                o_forward  <= all_met && is_perm;
                o_learn    <= all_met && is_perm;
                o_drop     <= all_met && !is_perm;
                o_shutdown <= all_met && is_shut;
            end
        end
    end

    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_arst_n);

    property p_dport_any;
        dport_mode == LFM_PORT_ANY |-> cmp.dport_ok;
    endproperty
    a_dport_any: assert property (p_dport_any)
        else $error("port any did not pass");

    property p_dport_single;
        dport_mode == LFM_PORT_SINGLE |->
            cmp.dport_ok == (i_frm_dport == dport_lo);
    endproperty
    a_dport_single: assert property (p_dport_single)
        else $error("single port compare wrong");

    property p_dport_range;
        dport_mode == LFM_PORT_RANGE |-> cmp.dport_ok ==
            (i_frm_dport >= dport_lo && i_frm_dport <= dport_hi);
    endproperty
    a_dport_range: assert property (p_dport_range)
        else $error("port range compare wrong");

    property p_flags;
        (&cmp.flags_ok) == ((((i_frm_tcp_flags ^ {flag_crit[10],
            flag_crit[8], flag_crit[6], flag_crit[4], flag_crit[2],
            flag_crit[0]}) & {flag_crit[11], flag_crit[9], flag_crit[7],
            flag_crit[5], flag_crit[3], flag_crit[1]})) == 6'h0);
    endproperty
    a_flags: assert property (p_flags)
        else $error("tcp flag criterion wrong");

    property p_tos;
        (tos_mode == LFM_TOS_ANY |-> cmp.tos_ok) and
        (tos_mode == LFM_TOS_DSCP |-> cmp.tos_ok == (i_frm_tos[7:2] == dscp));
    endproperty
    a_tos: assert property (p_tos)
        else $error("service criterion wrong");

    property p_prec;
        tos_mode == LFM_TOS_PREC |-> cmp.tos_ok == (i_frm_tos[7:5] == prec);
    endproperty
    a_prec: assert property (p_prec)
        else $error("precedence criterion wrong");

    property p_icmp;
        (!itype_en |-> cmp.itype_ok) and
        (itype_en |-> cmp.itype_ok == (i_frm_icmp_type == itype));
    endproperty
    a_icmp: assert property (p_icmp)
        else $error("icmp type criterion wrong");

    property p_icode;
        cmp.icode_ok == (!icode_en || i_frm_icmp_code == icode);
    endproperty
    a_icode: assert property (p_icode)
        else $error("icmp code criterion wrong");

    property p_mask;
        cmp.dip_ok |-> ((i_frm_dip ^ dip) & ~dip_mask) == 32'h0;
    endproperty
    a_mask: assert property (p_mask)
        else $error("address mask compare wrong");

    property p_hit;
        take |=> o_res_valid && (o_hit == $past(all_met));
    endproperty
    a_hit: assert property (p_hit)
        else $error("hit does not follow criteria");

    property p_action;
        take && all_met |=> o_hit && (o_forward == $past(is_perm)) &&
            (o_learn == o_forward) && (o_drop == !o_forward);
    endproperty
    a_action: assert property (p_action)
        else $error("action not applied on hit");

    c_permit: cover property (take && all_met && is_perm ##1 o_forward);
    c_deny:   cover property (take && all_met && !is_perm ##1 o_drop);
    c_range:  cover property (take && dport_mode == LFM_PORT_RANGE &&
                              all_met);
    c_miss:   cover property (take && ctrl_en && !all_met ##1 !o_hit);
endmodule // lfm_l4_matcher

// ==== hdl/lfm_defines.svh ====
`ifndef LFM_DEFINES_SVH
`define LFM_DEFINES_SVH

// Register byte offsets on the 8-bit register address.
`define LFM_OFF_CTRL      8'h00
`define LFM_OFF_DPORT_LO  8'h04
`define LFM_OFF_DPORT_HI  8'h08
`define LFM_OFF_FLAGS     8'h0C
`define LFM_OFF_TOS       8'h10
`define LFM_OFF_ICMP      8'h14
`define LFM_OFF_SIP       8'h18
`define LFM_OFF_SIP_MASK  8'h1C
`define LFM_OFF_DIP       8'h20
`define LFM_OFF_DIP_MASK  8'h24
`define LFM_OFF_STATUS    8'h28
`define LFM_OFF_HIT_CNT   8'h2C

// Control register fields.
`define LFM_CTRL_EN_BIT      0
`define LFM_CTRL_DPMODE_LSB  1
`define LFM_CTRL_TOSMODE_LSB 3
`define LFM_CTRL_ITYPE_BIT   5
`define LFM_CTRL_ICODE_BIT   6
`define LFM_CTRL_ACT_LSB     7

// Criterion value fields.
`define LFM_TOS_DSCP_LSB   0
`define LFM_TOS_PREC_LSB   8
`define LFM_ICMP_TYPE_LSB  0
`define LFM_ICMP_CODE_LSB  8

// Reset values.
`define LFM_RST_DPORT_LO  16'h0000
`define LFM_RST_DPORT_HI  16'hFFFF
`define LFM_RST_FLAGS     12'h000
`define LFM_RST_ADDR      32'h0000_0000
`define LFM_RST_MASK      32'hFFFF_FFFF

`endif

// ==== hdl/lfm_pkg.sv ====
package lfm_pkg;

    typedef enum logic [1:0] {
        LFM_PORT_ANY    = 2'h0,
        LFM_PORT_SINGLE = 2'h1,
        LFM_PORT_RANGE  = 2'h2
    } lfm_port_mode_e;

    typedef enum logic [1:0] {
        LFM_TOS_ANY  = 2'h0,
        LFM_TOS_DSCP = 2'h1,
        LFM_TOS_PREC = 2'h2
    } lfm_tos_mode_e;

    // Bit 1 says the flag is examined, bit 0 gives the wanted value.
    typedef enum logic [1:0] {
        LFM_FLAG_DONT_CARE = 2'h0,
        LFM_FLAG_UNSET     = 2'h2,
        LFM_FLAG_SET       = 2'h3
    } lfm_flag_e;

    typedef enum logic [1:0] {
        LFM_ACT_PERMIT   = 2'h0,
        LFM_ACT_DENY     = 2'h1,
        LFM_ACT_SHUTDOWN = 2'h2
    } lfm_action_e;

endpackage

// ==== hdl/lfm_cmp_if.sv ====
`timescale 1ns/10ps
interface lfm_cmp_if;
    import lfm_pkg::*;

    lfm_port_mode_e dport_mode;
    lfm_tos_mode_e  tos_mode;
    logic [15:0]    dport_lo;
    logic [15:0]    dport_hi;
    logic [11:0]    flag_crit;
    logic [5:0]     dscp;
    logic [2:0]     prec;
    logic           itype_en;
    logic [7:0]     itype;
    logic           icode_en;
    logic [7:0]     icode;
    logic [31:0]    sip;
    logic [31:0]    sip_mask;
    logic [31:0]    dip;
    logic [31:0]    dip_mask;
    logic [15:0]    frm_dport;
    logic [5:0]     frm_flags;
    logic [7:0]     frm_tos;
    logic [7:0]     frm_itype;
    logic [7:0]     frm_icode;
    logic [31:0]    frm_sip;
    logic [31:0]    frm_dip;
    logic           dport_ok;
    logic [5:0]     flags_ok;
    logic           tos_ok;
    logic           itype_ok;
    logic           icode_ok;
    logic           sip_ok;
    logic           dip_ok;

    modport src (
        output dport_mode, tos_mode, dport_lo, dport_hi, flag_crit, dscp,
        output prec, itype_en, itype, icode_en, icode, sip, sip_mask, dip,
        output dip_mask, frm_dport, frm_flags, frm_tos, frm_itype,
        output frm_icode, frm_sip, frm_dip,
        input  dport_ok, flags_ok, tos_ok, itype_ok, icode_ok, sip_ok, dip_ok
    );

    modport cmp (
        input  dport_mode, tos_mode, dport_lo, dport_hi, flag_crit, dscp,
        input  prec, itype_en, itype, icode_en, icode, sip, sip_mask, dip,
        input  dip_mask, frm_dport, frm_flags, frm_tos, frm_itype,
        input  frm_icode, frm_sip, frm_dip,
        output dport_ok, flags_ok, tos_ok, itype_ok, icode_ok, sip_ok, dip_ok
    );
endinterface

// ==== hdl/lfm_field_cmp.sv ====
`timescale 1ns/10ps
module lfm_field_cmp (
    // Criteria and frame fields in, per-criterion results out.
    lfm_cmp_if.cmp c
);
    import lfm_pkg::*;

    wire dport_eq = (c.frm_dport == c.dport_lo);
    wire dport_in = (c.frm_dport >= c.dport_lo) &&
                    (c.frm_dport <= c.dport_hi);
    wire dscp_eq  = (c.frm_tos[7:2] == c.dscp);
    wire prec_eq  = (c.frm_tos[7:5] == c.prec);

    always_comb begin
        unique case (c.dport_mode)
            LFM_PORT_ANY:    c.dport_ok = 1'b1;
            LFM_PORT_SINGLE: c.dport_ok = dport_eq;
            LFM_PORT_RANGE:  c.dport_ok = dport_in;
            default:         c.dport_ok = 1'b0;
        endcase
    end

    always_comb begin
        unique case (c.tos_mode)
            LFM_TOS_ANY:  c.tos_ok = 1'b1;
            LFM_TOS_DSCP: c.tos_ok = dscp_eq;
            LFM_TOS_PREC: c.tos_ok = prec_eq;
            default:      c.tos_ok = 1'b0;
        endcase
    end

    // Index 0 is FIN up to index 5 for URG.
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++) begin : g_flag
            assign c.flags_ok[gi] = !c.flag_crit[2*gi+1] ||
                (c.frm_flags[gi] == c.flag_crit[2*gi]);
        end
    endgenerate

    assign c.itype_ok = !c.itype_en || (c.frm_itype == c.itype);
    assign c.icode_ok = !c.icode_en || (c.frm_icode == c.icode);
    assign c.sip_ok   = ((c.frm_sip ^ c.sip) & ~c.sip_mask) == 32'h0;
    assign c.dip_ok   = ((c.frm_dip ^ c.dip) & ~c.dip_mask) == 32'h0;
endmodule // lfm_field_cmp

// ==== testbench/lfm_parser_model.sv ====
`timescale 1ns/10ps
module lfm_parser_model (
    // Clock.
    input  wire logic        i_ref_clk,
    // Header fields towards the matcher.
    output logic             o_frm_valid,
    output logic      [31:0] o_frm_sip,
    output logic      [31:0] o_frm_dip,
    output logic      [15:0] o_frm_dport,
    output logic      [5:0]  o_frm_tcp_flags,
    output logic      [7:0]  o_frm_tos,
    output logic      [7:0]  o_frm_icmp_type,
    output logic      [7:0]  o_frm_icmp_code
);
    initial begin
        o_frm_valid     = 1'h0;
        o_frm_sip       = 32'h0;
        o_frm_dip       = 32'h0;
        o_frm_dport     = 16'h0;
        o_frm_tcp_flags = 6'h0;
        o_frm_tos       = 8'h0;
        o_frm_icmp_type = 8'h0;
        o_frm_icmp_code = 8'h0;
    end

    // After its valid cycle the parser shows the inverse of the fields,
    // so a matcher that samples late sees wrong data, not stale data.
    task automatic send(input logic [31:0] sip, input logic [31:0] dip,
                        input logic [15:0] dp, input logic [5:0] fl,
                        input logic [7:0] tos, input logic [7:0] it,
                        input logic [7:0] ic);
        @(posedge i_ref_clk);
        o_frm_valid     <= 1'h1;
        o_frm_sip       <= sip;
        o_frm_dip       <= dip;
        o_frm_dport     <= dp;
        o_frm_tcp_flags <= fl;
        o_frm_tos       <= tos;
        o_frm_icmp_type <= it;
        o_frm_icmp_code <= ic;
        @(posedge i_ref_clk);
        o_frm_valid     <= 1'h0;
        o_frm_sip       <= ~sip;
        o_frm_dip       <= ~dip;
        o_frm_dport     <= ~dp;
        o_frm_tcp_flags <= ~fl;
        o_frm_tos       <= ~tos;
        o_frm_icmp_type <= ~it;
        o_frm_icmp_code <= ~ic;
    endtask
endmodule // lfm_parser_model

// ==== testbench/tb.sv ====
`timescale 1ns/10ps
`include "lfm_defines.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb;
    import lfm_pkg::*;

    logic        ref_clk, arst_n, wr_en, rd_en, frm_valid, clk_en;
    logic [7:0]  addr, frm_tos, frm_it, frm_ic;
    logic [31:0] wr_data, rd_data, frm_sip, frm_dip;
    logic [15:0] frm_dport, f_dp;
    logic [5:0]  frm_flags, f_fl;
    logic [7:0]  f_tos, f_it, f_ic;
    logic [31:0] f_sip;
    logic        res_valid, hit, fwd, learn, drop, shut;
    int          errors, num_checks;

    lfm_parser_model parser (.i_ref_clk(ref_clk), .o_frm_valid(frm_valid),
        .o_frm_sip(frm_sip), .o_frm_dip(frm_dip), .o_frm_dport(frm_dport),
        .o_frm_tcp_flags(frm_flags), .o_frm_tos(frm_tos),
        .o_frm_icmp_type(frm_it), .o_frm_icmp_code(frm_ic));

    lfm_l4_matcher dut (.i_ref_clk(ref_clk), .i_arst_n(arst_n),
        .i_clk_en(clk_en), .i_addr(addr), .i_wr_data(wr_data),
        .i_wr_en(wr_en), .i_rd_en(rd_en), .o_rd_data(rd_data),
        .i_frm_valid(frm_valid), .i_frm_sip(frm_sip), .i_frm_dip(frm_dip),
        .i_frm_dport(frm_dport), .i_frm_tcp_flags(frm_flags),
        .i_frm_tos(frm_tos), .i_frm_icmp_type(frm_it),
        .i_frm_icmp_code(frm_ic), .o_res_valid(res_valid), .o_hit(hit),
        .o_forward(fwd), .o_learn(learn), .o_drop(drop),
        .o_shutdown(shut));

    initial begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        addr    <= a;
        wr_data <= d;
        wr_en   <= 1'h1;
        @(posedge ref_clk);
        wr_en   <= 1'h0;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                          input string nm);
        @(posedge ref_clk);
        addr  <= a;
        rd_en <= 1'h1;
        @(posedge ref_clk);
        rd_en <= 1'h0;
        #1;
        `CHK(nm, e, rd_data)
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] pm,
        input logic [1:0] tm, input logic ite, input logic ice,
        input logic [1:0] act);
        return {23'h0, act, ice, ite, tm, pm, 1'h1};
    endfunction

    task automatic dflt();
        f_dp  = 16'h0050;
        f_fl  = 6'h00;
        f_tos = 8'h00;
        f_it  = 8'h00;
        f_ic  = 8'h00;
        f_sip = 32'h0;
    endtask

    // The result is registered on the taken edge and checked 1 ns after it.
    task automatic frm(input logic e, input string nm);
        parser.send(f_sip, 32'h0, f_dp, f_fl, f_tos, f_it, f_ic);
        #1;
        `CHK({nm, " valid"}, 1'h1, res_valid)
        `CHK(nm, e, hit)
    endtask

    task automatic s_regs();
        rd_chk(`LFM_OFF_CTRL, 32'h0, "ctrl rst");
        rd_chk(`LFM_OFF_DPORT_HI, 32'h0000FFFF, "dport hi rst");
        rd_chk(`LFM_OFF_SIP_MASK, 32'hFFFFFFFF, "sip mask rst");
        rd_chk(8'h30, 32'h0, "unmapped");
        wr(`LFM_OFF_DPORT_LO, 32'hFFFF1234);
        rd_chk(`LFM_OFF_DPORT_LO, 32'h00001234, "dport lo rb");
        dflt();
        frm(1'h0, "disabled");
    endtask

    task automatic s_port();
        dflt();
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_ANY, LFM_TOS_ANY, 1'h0, 1'h0, 2'h0));
        f_dp = 16'hFFFF;
        frm(1'h1, "port any");
        wr(`LFM_OFF_DPORT_LO, 32'h0000FFFF);
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_SINGLE, 2'h0, 1'h0, 1'h0, 2'h0));
        frm(1'h1, "single max");
        f_dp = 16'hFFFE;
        frm(1'h0, "single ne");
        wr(`LFM_OFF_DPORT_LO, 32'h0000000A);
        wr(`LFM_OFF_DPORT_HI, 32'h00000014);
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_RANGE, 2'h0, 1'h0, 1'h0, 2'h0));
        f_dp = 16'h0009;
        frm(1'h0, "range below");
        f_dp = 16'h000A;
        frm(1'h1, "range low");
        f_dp = 16'h0014;
        frm(1'h1, "range high");
        f_dp = 16'h0015;
        frm(1'h0, "range above");
        wr(`LFM_OFF_CTRL, ctrl(2'h3, 2'h0, 1'h0, 1'h0, 2'h0));
        frm(1'h0, "port mode 3");
    endtask

    task automatic s_flags();
        dflt();
        wr(`LFM_OFF_CTRL, ctrl(2'h0, 2'h0, 1'h0, 1'h0, 2'h0));
        f_fl = 6'h3F;
        frm(1'h1, "flags dont care");
        for (int i = 0; i < 6; i++) begin
            wr(`LFM_OFF_FLAGS, 32'h3 << (2 * i));
            f_fl = 6'h1 << i;
            frm(1'h1, "flag set hit");
            f_fl = ~(6'h1 << i);
            frm(1'h0, "flag set miss");
            wr(`LFM_OFF_FLAGS, 32'h2 << (2 * i));
            frm(1'h1, "flag unset hit");
            f_fl = 6'h1 << i;
            frm(1'h0, "flag unset miss");
        end
        wr(`LFM_OFF_FLAGS, 32'h0);
    endtask

    task automatic s_tos_icmp();
        dflt();
        wr(`LFM_OFF_TOS, 32'h0000052E);
        wr(`LFM_OFF_ICMP, 32'h0000FF08);
        f_tos = 8'h5C;
        frm(1'h1, "tos any");
        wr(`LFM_OFF_CTRL, ctrl(2'h0, LFM_TOS_DSCP, 1'h0, 1'h0, 2'h0));
        f_tos = 8'hB9;
        frm(1'h1, "dscp eq");
        f_tos = 8'hBC;
        frm(1'h0, "dscp ne");
        wr(`LFM_OFF_CTRL, ctrl(2'h0, LFM_TOS_PREC, 1'h0, 1'h0, 2'h0));
        frm(1'h1, "prec eq");
        f_tos = 8'h9F;
        frm(1'h0, "prec ne");
        wr(`LFM_OFF_CTRL, ctrl(2'h0, 2'h0, 1'h1, 1'h0, 2'h0));
        f_it = 8'h08;
        frm(1'h1, "itype eq");
        f_it = 8'h09;
        frm(1'h0, "itype ne");
        wr(`LFM_OFF_CTRL, ctrl(2'h0, 2'h0, 1'h0, 1'h1, 2'h0));
        f_ic = 8'hFF;
        frm(1'h1, "icode eq");
        f_ic = 8'hFE;
        frm(1'h0, "icode ne");
    endtask

    task automatic s_act_mask();
        dflt();
        wr(`LFM_OFF_HIT_CNT, 32'h0);
        wr(`LFM_OFF_SIP, 32'h0A000000);
        wr(`LFM_OFF_SIP_MASK, 32'h000000FF);
        wr(`LFM_OFF_DPORT_LO, 32'h00000050);
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_SINGLE, LFM_TOS_PREC, 1'h0, 1'h0,
                               LFM_ACT_PERMIT));
        f_sip = 32'h0A0000FF;
        f_tos = 8'hA0;
        frm(1'h1, "all met");
        `CHK("forward", 1'h1, fwd)
        `CHK("learn", 1'h1, learn)
        `CHK("no drop", 1'h0, drop)
        rd_chk(`LFM_OFF_STATUS, 32'h3, "status");
        f_tos = 8'h00;
        frm(1'h0, "one unmet");
        `CHK("miss forward", 1'h0, fwd)
        f_tos = 8'hA0;
        f_sip = 32'h0A000100;
        frm(1'h0, "mask cmp");
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_SINGLE, LFM_TOS_PREC, 1'h0, 1'h0,
                               LFM_ACT_DENY));
        f_sip = 32'h0A000000;
        frm(1'h1, "deny hit");
        `CHK("deny drop", 1'h1, drop)
        `CHK("deny forward", 1'h0, fwd)
        `CHK("deny learn", 1'h0, learn)
        `CHK("deny shut", 1'h0, shut)
        wr(`LFM_OFF_CTRL, ctrl(LFM_PORT_SINGLE, LFM_TOS_PREC, 1'h0, 1'h0,
                               LFM_ACT_SHUTDOWN));
        frm(1'h1, "shut hit");
        `CHK("shut flag", 1'h1, shut)
        `CHK("shut drop", 1'h1, drop)
        `CHK("shut forward", 1'h0, fwd)
    endtask

    // A frame offered while the clock enable is low must leave no trace.
    task automatic s_freeze();
        @(posedge ref_clk);
        clk_en <= 1'h0;
        f_sip = 32'h0A000100;
        parser.send(f_sip, 32'h0, f_dp, f_fl, f_tos, f_it, f_ic);
        #1;
        `CHK("frozen valid", 1'h0, res_valid)
        `CHK("frozen hit", 1'h1, hit)
        @(posedge ref_clk);
        clk_en <= 1'h1;
        frm(1'h0, "thawed miss");
        rd_chk(`LFM_OFF_HIT_CNT, 32'h3, "hit count");
    endtask

    initial begin
        errors     = 0;
        num_checks = 0;
        arst_n     = 1'h0;
        addr       = 8'h0;
        wr_data    = 32'h0;
        wr_en      = 1'h0;
        rd_en      = 1'h0;
        clk_en     = 1'h1;
        repeat (5) @(posedge ref_clk);
        arst_n <= 1'h1;
        s_regs();
        s_port();
        s_flags();
        s_tos_icmp();
        s_act_mask();
        s_freeze();
        wrap_up();
    end

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        wrap_up();
    end
endmodule // tb
